// >>> logic/flp_pkg.sv
/*
 * Shared constants for the flash latch and programming launch block: control
 * register layout, key values, space codes, address windows and timing.
 * Assumes a single 50 MHz core clock shared by the CPU end and the flash end.
 */
package flp_pkg;

   // Clock and timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int SETTLE_TIME_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 1);

   // Flash control register layout.
   localparam int FC_KEY_LSB = 4;
   localparam int FC_MAP_BIT = 3;
   localparam int FC_SPACE_LSB = 1;
   localparam int FC_BUSY_BIT = 0;
   localparam logic [7:0] FLASH_CONTROL_REG_RESET = 8'h00;
   localparam logic [3:0] KEY_ARM = 4'h5;
   localparam logic [3:0] KEY_FIRE = 4'hA;

   // Auxiliary control register layout.
   localparam int AUX_BOOT_BIT = 5;
   localparam logic AUX_BOOT_RESET = 1'b0;

   // Space select codes.
   localparam logic [1:0] SP_USER = 2'h0;
   localparam logic [1:0] SP_XROW = 2'h1;
   localparam logic [1:0] SP_SEC = 2'h2;
   localparam logic [1:0] SP_RSVD = 2'h3;

   // Address windows and page split.
   localparam logic [15:0] USER_LAST = 16'h3FFF;
   localparam logic [15:0] XROW_BASE = 16'hFF80;
   localparam logic [15:0] SEC_ADDR = 16'h0000;
   localparam logic [15:0] BOOT_BASE = 16'hF800;
   localparam int PAGE_BYTES = 128;
   localparam int USER_BYTES = 16384;
   localparam int COL_MSB = 6;
   localparam int PAGE_LSB = 7;
   localparam int PAGE_MSB = 14;
   localparam logic [6:0] COL_LAST = 7'h7F;

   // Cell values.
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] SEC_RESET = 8'hFF;
   localparam logic [7:0] SEC_WMASK = 8'hF0;
   localparam logic [7:0] NO_CELL = 8'hFF;

   // Code source tags reported with each code read.
   localparam logic [1:0] SRC_USER = 2'h0;
   localparam logic [1:0] SRC_XROW = 2'h1;
   localparam logic [1:0] SRC_SEC = 2'h2;
   localparam logic [1:0] SRC_BOOT = 2'h3;

   // CPU end software port map.
   localparam logic [3:0] H_FLASH_CONTROL_REG = 4'h0;
   localparam logic [3:0] H_AUX = 4'h1;
   localparam logic [3:0] H_LADDR = 4'h2;
   localparam logic [3:0] H_LDATA = 4'h3;
   localparam logic [3:0] H_NOP = 4'h4;
   localparam logic [3:0] H_CODE = 4'h5;
   localparam logic [3:0] H_MODE = 4'h6;
   localparam logic [3:0] H_STAT = 4'h7;
   localparam logic [3:0] H_LAUNCH = 4'h8;

endpackage

// >>> logic/flp_link_if.sv
/*
 * Link between the CPU end and the flash end: special function register
 * writes, external-data writes, code reads and an instruction retire pulse.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/10ps
interface flp_link_if (
   input logic core_clk_i,
   input logic rst_b_i
);
   logic flash_control_reg_wr;
   logic aux_wr;
   logic [7:0] sfr_wdata;
   logic xdata_wr;
   logic [15:0] xdata_addr;
   logic [7:0] xdata_wdata;
   logic instr_done;
   logic exec_boot;
   logic code_rd;
   logic [15:0] code_addr;
   logic [7:0] flash_control_reg_rdata;
   logic [7:0] aux_rdata;
   logic latch_claim;
   logic [7:0] code_rdata;
   logic [1:0] code_src;
   logic code_valid;

   modport dev (
      input flash_control_reg_wr, aux_wr, sfr_wdata, xdata_wr, xdata_addr, xdata_wdata,
      input instr_done, exec_boot, code_rd, code_addr,
      output flash_control_reg_rdata, aux_rdata, latch_claim, code_rdata, code_src, code_valid
   );

   modport cpu (
      output flash_control_reg_wr, aux_wr, sfr_wdata, xdata_wr, xdata_addr, xdata_wdata,
      output instr_done, exec_boot, code_rd, code_addr,
      input flash_control_reg_rdata, aux_rdata, latch_claim, code_rdata, code_src, code_valid
   );
endinterface

// >>> logic/flp_dev.sv
/*
 * Flash end: control register, column latches, key sequencer, erase and
 * program engine and the code space mapping of user array, extra row,
 * security byte and boot window.
 * Assumes the CPU end pulses instr_done once per retired instruction, in the
 * same cycle as any register or external-data write made by it.
 */
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Space select maps user, extra row, security.
// - Launch only after key 5 then A.
// - Second key acts on space; reserved does nothing.
// - Key writes back to back, else abort.
// - Software keeps interrupts off while programming.
// - Busy flag high from launch until done.
// - Boot bit maps boot flash at F800h-FFFFh; with extra row space selected, FF80h-FFFFh reads the extra row.
// - Latches take one to 128 bytes.
// - Erase loaded bytes only, then program them.
// - Last loaded page address selects programmed page.
// - Latch map bit steers external writes to latches.
// - Software loads user latches within 0000h-3FFFh.
// - User launch is 50h then A0h.
// - Extra row launch is 52h then A2h.
// - Address bits 6-0 column, 14-7 page.
// - Latch mapping beats the EEPROM mapping.
// - Control register fields: key, map, space, busy.
// - Launch from user array never programs.
module flp_dev
   import flp_pkg::*;
(
   // Clock and reset.
   input logic core_clk_i,
   input logic rst_b_i,
   // Link to the CPU end.
   flp_link_if.dev lnk
);

   typedef enum logic [0:0] {
      KEY_IDLE = 1'b0,
      KEY_ARMED = 1'b1
   } flp_key_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG = 2'b10,
      ST_SETTLE = 2'b11
   } flp_seq_t;

   typedef struct packed {
      flp_key_t key;
      flp_seq_t seq;
      logic map;
      logic [1:0] space;
      logic busy;
      logic [1:0] tgt;
      logic [7:0] page;
      logic [PAGE_BYTES-1:0] loaded;
      logic [6:0] col;
      logic [5:0] cnt;
      logic boot;
      logic [7:0] sec;
      logic [7:0] code_data;
      logic [1:0] code_src;
      logic code_valid;
   } flp_dev_st_t;

   flp_dev_st_t s_q;
   flp_dev_st_t s_d;

   // Arrays are kept outside the state record; they need no reset.
   logic [7:0] latch_mem [PAGE_BYTES];
   logic [7:0] user_mem [USER_BYTES];
   logic [7:0] xrow_mem [PAGE_BYTES];

   logic lat_we;
   logic mem_we;
   logic [7:0] mem_data;
   logic [3:0] key_nib;
   logic [1:0] wr_space;
   logic [15:0] ca;

   assign key_nib = lnk.sfr_wdata[FC_KEY_LSB +: 4];
   assign wr_space = lnk.sfr_wdata[FC_SPACE_LSB +: 2];
   assign ca = lnk.code_addr;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      lat_we = 1'b0;
      mem_we = 1'b0;
      mem_data = ERASED;
      s_d.code_valid = 1'b0;

      // Register writes and the launch key.
      if (lnk.flash_control_reg_wr) begin
         s_d.map = lnk.sfr_wdata[FC_MAP_BIT];
         s_d.space = wr_space;
         s_d.key = KEY_IDLE;
         if (s_q.seq == ST_IDLE && key_nib == KEY_ARM) begin
            s_d.key = KEY_ARMED;
         end else if (s_q.seq == ST_IDLE && key_nib == KEY_FIRE && s_q.key == KEY_ARMED) begin
            // Code running from the user array may not start a write at all.
            if (wr_space != SP_RSVD && lnk.exec_boot) begin
               s_d.seq = ST_ERASE;
               s_d.tgt = wr_space;
               s_d.col = 7'h00;
               s_d.cnt = 6'h00;
            end
         end
      end else if (lnk.instr_done) begin
         s_d.key = KEY_IDLE;
      end

      if (lnk.aux_wr) begin
         s_d.boot = lnk.sfr_wdata[AUX_BOOT_BIT];
      end

      // Latch loads; refused while the engine runs so the page stays stable.
      if (lnk.xdata_wr && s_q.map && s_q.seq == ST_IDLE) begin
         lat_we = 1'b1;
         s_d.page = lnk.xdata_addr[PAGE_MSB:PAGE_LSB];
         s_d.loaded[lnk.xdata_addr[COL_MSB:0]] = 1'b1;
      end

      // Erase then program engine, one column per cycle.
      case (s_q.seq)
         ST_IDLE: begin
         end
         ST_ERASE: begin
            mem_we = s_q.loaded[s_q.col];
            mem_data = ERASED;
            s_d.col = s_q.col + 7'h01;
            if (s_q.col == COL_LAST) begin
               s_d.seq = ST_PROG;
            end
         end
         ST_PROG: begin
            mem_we = s_q.loaded[s_q.col];
            mem_data = latch_mem[s_q.col];
            s_d.col = s_q.col + 7'h01;
            if (s_q.col == COL_LAST) begin
               s_d.seq = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt == SETTLE_LAST) begin
               s_d.seq = ST_IDLE;
               s_d.loaded = '0;
            end
         end
         default: begin
            s_d.seq = ST_IDLE;
         end
      endcase

      // Only the software-writable upper nibble of the security byte changes.
      if (mem_we && s_q.tgt == SP_SEC && s_q.col == 7'h00) begin
         s_d.sec = (s_q.sec & ~SEC_WMASK) | (mem_data & SEC_WMASK);
      end

      s_d.busy = (s_d.seq != ST_IDLE);

      // Code space mapping.
      if (lnk.code_rd) begin
         s_d.code_valid = 1'b1;
         s_d.code_data = NO_CELL;
         s_d.code_src = SRC_USER;
         if (s_q.space == SP_XROW && ca >= XROW_BASE) begin
            s_d.code_data = xrow_mem[ca[COL_MSB:0]];
            s_d.code_src = SRC_XROW;
         end else if (s_q.boot && ca >= BOOT_BASE) begin
            // Boot contents live outside this block; only the selection is shown.
            s_d.code_data = 8'h00;
            s_d.code_src = SRC_BOOT;
         end else if (s_q.space == SP_SEC && ca == SEC_ADDR) begin
            s_d.code_data = s_q.sec;
            s_d.code_src = SRC_SEC;
         end else if (s_q.space == SP_USER && ca <= USER_LAST) begin
            s_d.code_data = user_mem[ca[13:0]];
            s_d.code_src = SRC_USER;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '{key: KEY_IDLE, seq: ST_IDLE, map: FLASH_CONTROL_REG_RESET[FC_MAP_BIT],
                  space: FLASH_CONTROL_REG_RESET[FC_SPACE_LSB +: 2], busy: 1'b0, tgt: SP_USER,
                  page: 8'h00, loaded: '0, col: 7'h00, cnt: 6'h00,
                  boot: AUX_BOOT_RESET, sec: SEC_RESET, code_data: 8'h00,
                  code_src: SRC_USER, code_valid: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (lat_we) begin
         latch_mem[lnk.xdata_addr[COL_MSB:0]] <= lnk.xdata_wdata;
      end
      if (mem_we && s_q.tgt == SP_USER) begin
         user_mem[{s_q.page[6:0], s_q.col}] <= mem_data;
      end
      if (mem_we && s_q.tgt == SP_XROW) begin
         xrow_mem[s_q.col] <= mem_data;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   assign lnk.flash_control_reg_rdata = {4'h0, s_q.map, s_q.space, s_q.busy};
   assign lnk.aux_rdata = 8'(s_q.boot) << AUX_BOOT_BIT;
   assign lnk.latch_claim = s_q.map;
   assign lnk.code_rdata = s_q.code_data;
   assign lnk.code_src = s_q.code_src;
   assign lnk.code_valid = s_q.code_valid;

endmodule // flp_dev

// >>> logic/flp_cpu.sv
/*
 * CPU end: turns software port writes into single-instruction register,
 * external-data and code accesses, and issues the two-write launch key.
 * Assumes software issues strobes as one-cycle pulses, never both at once.
 */
`timescale 1ns/10ps
module flp_cpu
   import flp_pkg::*;
(
   // Clock and reset.
   input logic core_clk_i,
   input logic rst_b_i,
   // Software port.
   input logic [3:0] sw_addr_i,
   input logic [15:0] sw_wdata_i,
   input logic sw_wr_i,
   input logic sw_rd_i,
   output logic [15:0] sw_rdata_o,
   // Link to the flash end.
   flp_link_if.cpu lnk
);

   typedef struct packed {
      logic flash_control_reg_wr;
      logic aux_wr;
      logic [7:0] sfr_wdata;
      logic xdata_wr;
      logic [15:0] xaddr;
      logic [7:0] xdata;
      logic instr_done;
      logic exec_boot;
      logic code_rd;
      logic [15:0] code_addr;
      logic [7:0] code_data;
      logic [1:0] code_src;
      logic fire_pend;
      logic [1:0] fire_space;
      logic [15:0] rdata;
   } flp_cpu_st_t;

   flp_cpu_st_t s_q;
   flp_cpu_st_t s_d;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.flash_control_reg_wr = 1'b0;
      s_d.aux_wr = 1'b0;
      s_d.xdata_wr = 1'b0;
      s_d.instr_done = 1'b0;
      s_d.code_rd = 1'b0;
      s_d.fire_pend = 1'b0;

      if (lnk.code_valid) begin
         s_d.code_data = lnk.code_rdata;
         s_d.code_src = lnk.code_src;
      end

      // The second key write follows at once, so no instruction can slip in.
      if (s_q.fire_pend) begin
         s_d.flash_control_reg_wr = 1'b1;
         s_d.instr_done = 1'b1;
         s_d.sfr_wdata = {KEY_FIRE, 1'b0, s_q.fire_space, 1'b0};
      end else if (sw_wr_i) begin
         case (sw_addr_i)
            H_FLASH_CONTROL_REG: begin
               s_d.flash_control_reg_wr = 1'b1;
               s_d.instr_done = 1'b1;
               s_d.sfr_wdata = sw_wdata_i[7:0];
            end
            H_AUX: begin
               s_d.aux_wr = 1'b1;
               s_d.instr_done = 1'b1;
               s_d.sfr_wdata = sw_wdata_i[7:0];
            end
            H_LADDR: begin
               s_d.xaddr = sw_wdata_i;
            end
            H_LDATA: begin
               s_d.xdata_wr = 1'b1;
               s_d.instr_done = 1'b1;
               s_d.xdata = sw_wdata_i[7:0];
            end
            H_NOP: begin
               s_d.instr_done = 1'b1;
            end
            H_CODE: begin
               s_d.code_rd = 1'b1;
               s_d.instr_done = 1'b1;
               s_d.code_addr = sw_wdata_i;
            end
            H_MODE: begin
               s_d.exec_boot = sw_wdata_i[0];
            end
            H_LAUNCH: begin
               s_d.flash_control_reg_wr = 1'b1;
               s_d.instr_done = 1'b1;
               s_d.sfr_wdata = {KEY_ARM, 1'b0, sw_wdata_i[1:0], 1'b0};
               s_d.fire_pend = 1'b1;
               s_d.fire_space = sw_wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end

      s_d.rdata = 16'h0000;
      if (sw_rd_i) begin
         case (sw_addr_i)
            H_FLASH_CONTROL_REG: s_d.rdata = {8'h00, lnk.flash_control_reg_rdata};
            H_AUX: s_d.rdata = {8'h00, lnk.aux_rdata};
            H_LADDR: s_d.rdata = s_q.xaddr;
            H_CODE: s_d.rdata = {6'h00, s_q.code_src, s_q.code_data};
            H_MODE: s_d.rdata = {15'h0000, s_q.exec_boot};
            H_STAT: s_d.rdata = {14'h0000, lnk.latch_claim, lnk.flash_control_reg_rdata[FC_BUSY_BIT]};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lnk.flash_control_reg_wr = s_q.flash_control_reg_wr;
   assign lnk.aux_wr = s_q.aux_wr;
   assign lnk.sfr_wdata = s_q.sfr_wdata;
   assign lnk.xdata_wr = s_q.xdata_wr;
   assign lnk.xdata_addr = s_q.xaddr;
   assign lnk.xdata_wdata = s_q.xdata;
   assign lnk.instr_done = s_q.instr_done;
   assign lnk.exec_boot = s_q.exec_boot;
   assign lnk.code_rd = s_q.code_rd;
   assign lnk.code_addr = s_q.code_addr;
   assign sw_rdata_o = s_q.rdata;

endmodule // flp_cpu

// >>> tb/flp_chk.sv
/*
 * Checker for the flash latch link: key sequence, busy timing, code mapping.
 * Assumes one clock and the active-low reset of the link, seen as plain inputs.
 */
`timescale 1ns/10ps
module flp_chk
   import flp_pkg::*;
(
   // Clock and reset.
   input logic core_clk_i,
   input logic rst_b_i,
   // Link signals.
   input logic flash_control_reg_wr,
   input logic [7:0] sfr_wdata,
   input logic instr_done,
   input logic exec_boot,
   input logic code_rd,
   input logic [15:0] code_addr,
   input logic [7:0] flash_control_reg_rdata,
   input logic [7:0] aux_rdata,
   input logic latch_claim,
   input logic [7:0] code_rdata,
   input logic [1:0] code_src,
   input logic code_valid
);
   localparam int BUSY_CYC = 2 * PAGE_BYTES + SETTLE_CYC;
   logic busy;
   logic arm_w;
   logic fire_w;
   logic armed_q;
   logic [8:0] cnt_q;
   assign busy = flash_control_reg_rdata[FC_BUSY_BIT];
   assign arm_w = flash_control_reg_wr && (sfr_wdata[7:4] == KEY_ARM) && !busy;
   assign fire_w = flash_control_reg_wr && (sfr_wdata[7:4] == KEY_FIRE);
   // Any retired instruction other than a control write breaks the key pair.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         armed_q <= 1'b0;
         cnt_q <= 9'h000;
      end else begin
         armed_q <= flash_control_reg_wr ? arm_w : (instr_done ? 1'b0 : armed_q);
         cnt_q <= busy ? cnt_q + 9'h001 : 9'h000;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   //////////////////////////////////////////////////////////////////////////
   AST_LAUNCH_GO: assert property (
      fire_w && armed_q && exec_boot && sfr_wdata[2:1] != SP_RSVD && !busy |=> busy)
      else $error("launch did not raise busy");
   AST_NO_ARM: assert property (
      fire_w && !armed_q && !busy |=> !busy) else $error("unarmed launch");
   AST_RSVD: assert property (
      fire_w && sfr_wdata[2:1] == SP_RSVD && !busy |=> !busy) else $error("reserved launch");
   AST_FROM_USER: assert property (
      fire_w && !exec_boot && !busy |=> !busy) else $error("launch from user code");
   AST_BUSY_LEN: assert property (
      $fell(busy) |-> cnt_q == BUSY_CYC) else $error("busy length wrong");
   AST_BUSY_MAX: assert property (
      busy |-> cnt_q < BUSY_CYC) else $error("busy too long");
   AST_CODE_ANS: assert property (
      code_rd |=> code_valid) else $error("code read unanswered");
   AST_XROW: assert property (
      code_rd && flash_control_reg_rdata[2:1] == SP_XROW && code_addr >= XROW_BASE |=> code_src == SRC_XROW)
      else $error("extra row not mapped");
   AST_SEC: assert property (
      code_rd && flash_control_reg_rdata[2:1] == SP_SEC && code_addr == SEC_ADDR |=> code_src == SRC_SEC)
      else $error("security byte not mapped");
   AST_BOOT: assert property (
      code_rd && aux_rdata[AUX_BOOT_BIT] && code_addr >= BOOT_BASE
      && flash_control_reg_rdata[2:1] != SP_XROW |=> code_src == SRC_BOOT && code_rdata == 8'h00)
      else $error("boot window not mapped");
   AST_CLAIM: assert property (
      flash_control_reg_wr |=> latch_claim == $past(sfr_wdata[FC_MAP_BIT]))
      else $error("claim not following map bit");
   AST_MAP_WR: assert property (
      flash_control_reg_wr && !busy && sfr_wdata[7:4] == 4'h0 |=> flash_control_reg_rdata[3:1] == $past(sfr_wdata[3:1]))
      else $error("control fields not written");
   COV_LAUNCH: cover property (fire_w && armed_q && exec_boot);
   COV_ABORT: cover property (fire_w && !armed_q);
   COV_BOOT: cover property (code_rd && aux_rdata[AUX_BOOT_BIT]);
endmodule // flp_chk

// >>> tb/tb_top.sv
/*
 * Bench: CPU end and flash end joined by the link, driven through the
 * software port, compared with a byte model of latches and arrays.
 * Assumes the package and link interface are compiled first.
 */
`timescale 1ns/10ps
module tb_top;
   import flp_pkg::*;
   logic core_clk_i;
   logic rst_b_i;
   logic [3:0] sw_addr_i;
   logic [15:0] sw_wdata_i;
   logic sw_wr_i;
   logic sw_rd_i;
   logic [15:0] sw_rdata_o;
   logic [16:0] lfsr_q;
   logic [15:0] v;
   logic [7:0] lat [128];
   bit ld [128];
   logic [7:0] um [int];
   logic [7:0] xr [int];
   int pg;
   logic [7:0] sb;
   int fail_count;
   int samples_checked;
   flp_link_if lnk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i));
   flp_cpu flp_cpu_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .sw_addr_i(sw_addr_i),
      .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
      .sw_rdata_o(sw_rdata_o), .lnk(lnk));
   flp_dev flp_dev_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .lnk(lnk));
   flp_chk flp_chk_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .flash_control_reg_wr(lnk.flash_control_reg_wr),
      .sfr_wdata(lnk.sfr_wdata), .instr_done(lnk.instr_done), .exec_boot(lnk.exec_boot),
      .code_rd(lnk.code_rd), .code_addr(lnk.code_addr), .flash_control_reg_rdata(lnk.flash_control_reg_rdata),
      .aux_rdata(lnk.aux_rdata), .latch_claim(lnk.latch_claim), .code_rdata(lnk.code_rdata),
      .code_src(lnk.code_src), .code_valid(lnk.code_valid));
   //////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[15:0], lfsr_q[16] ^ lfsr_q[13]};
      return lfsr_q[7:0];
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      sw_addr_i <= a;
      sw_wdata_i <= d;
      sw_wr_i <= 1'b1;
      @(posedge core_clk_i);
      sw_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      sw_addr_i <= a;
      sw_rd_i <= 1'b1;
      @(posedge core_clk_i);
      sw_rd_i <= 1'b0;
      #1;
      d = sw_rdata_o;
      @(posedge core_clk_i);
   endtask
   task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_code(input logic [15:0] a, input logic [1:0] s, input logic [7:0] d);
      wr(H_CODE, a);
      repeat (2) @(posedge core_clk_i);
      rd(H_CODE, v);
      samples_checked++;
      if (v[9:0] !== {s, d}) begin
         fail_count++;
         $display("BAD t=%0t code got %h exp %h", $time, v[9:0], {s, d});
      end
   endtask
   // Latch load: the model keeps only the last page, as the device does.
   task automatic load(input logic [15:0] a);
      logic [7:0] d;
      d = rnd();
      wr(H_LADDR, a);
      wr(H_LDATA, {8'h00, d});
      lat[a[COL_MSB:0]] = d;
      ld[a[COL_MSB:0]] = 1'b1;
      pg = a[PAGE_MSB:PAGE_LSB];
   endtask
   task automatic fire(input int sp);
      for (int c = 0; c < PAGE_BYTES; c++) begin
         if (ld[c] && sp == 0) um[pg * PAGE_BYTES + c] = lat[c];
         if (ld[c] && sp == 1) xr[c] = lat[c];
         if (ld[c] && sp == 2 && c == 0) begin
            sb = (sb & ~SEC_WMASK) | (lat[c] & SEC_WMASK);
         end
         ld[c] = 1'b0;
      end
   endtask
   task automatic wait_idle(input bit e);
      int n;
      n = 0;
      @(posedge core_clk_i);
      rd(H_STAT, v);
      cmp_reg(v & 16'h0001, {15'h0000, e});
      while (v[0] === 1'b1 && n < 400) begin
         rd(H_STAT, v);
         n++;
      end
      if (n >= 400) fail_count++;
   endtask
   task automatic chk_page();
      int cols [3] = '{0, 3, 127};
      foreach (cols[k]) begin
         cmp_code(16'(9 * PAGE_BYTES + cols[k]), SRC_USER, um[9 * 128 + cols[k]]);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   initial begin
      #(CLK_PERIOD_NS * 20000);
      fail_count++;
      stop_test();
   end
   initial begin
      {sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i} = '0;
      {fail_count, samples_checked, pg} = '0;
      lfsr_q = 17'h110DC;
      sb = SEC_RESET;
      rst_b_i = 1'b0;
      repeat (3) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      @(posedge core_clk_i);
      rd(H_FLASH_CONTROL_REG, v);
      cmp_reg(v, 16'h0000);
      wr(H_AUX, 16'h0020);
      rd(H_AUX, v);
      cmp_reg(v, 16'h0020);
      cmp_code(16'hF800, SRC_BOOT, 8'h00);
      wr(H_AUX, 16'h0000);
      wr(H_FLASH_CONTROL_REG, 16'h0004);
      cmp_code(16'h0000, SRC_SEC, SEC_RESET);
      // Two user runs: the second reloads one column only, the rest must survive.
      wr(H_MODE, 16'h0001);
      wr(H_FLASH_CONTROL_REG, 16'h0008);
      rd(H_STAT, v);
      cmp_reg(v, 16'h0002);
      load(16'h0280);
      load(16'h02FF);
      load(16'h0483);
      // Nothing is issued between the key writes, as if interrupts were held off.
      wr(H_LAUNCH, 16'h0000);
      fire(0);
      wait_idle(1'b1);
      chk_page();
      wr(H_FLASH_CONTROL_REG, 16'h0008);
      load(16'h0483);
      wr(H_LAUNCH, 16'h0000);
      fire(0);
      wait_idle(1'b1);
      chk_page();
      // Refused launches: broken pair, user code, reserved space.
      wr(H_FLASH_CONTROL_REG, 16'h0008);
      load(16'h0480);
      wr(H_FLASH_CONTROL_REG, 16'h0050);
      wr(H_NOP, 16'h0000);
      wr(H_FLASH_CONTROL_REG, 16'h00A0);
      wait_idle(1'b0);
      wr(H_MODE, 16'h0000);
      wr(H_LAUNCH, 16'h0000);
      wait_idle(1'b0);
      wr(H_MODE, 16'h0001);
      wr(H_LAUNCH, 16'h0003);
      wait_idle(1'b0);
      wr(H_FLASH_CONTROL_REG, 16'h0000);
      chk_page();
      // An idle gap is not an instruction, so this pair still launches.
      wr(H_FLASH_CONTROL_REG, 16'h0050);
      wr(H_FLASH_CONTROL_REG, 16'h00A0);
      fire(0);
      wait_idle(1'b1);
      chk_page();
      wr(H_FLASH_CONTROL_REG, 16'h0008);
      load(16'hFF85);
      load(16'hFFFF);
      wr(H_LAUNCH, 16'h0001);
      fire(1);
      wait_idle(1'b1);
      wr(H_FLASH_CONTROL_REG, 16'h0002);
      cmp_code(16'hFF85, SRC_XROW, xr[5]);
      cmp_code(16'hFFFF, SRC_XROW, xr[127]);
      // Security byte: only the upper nibble of column zero is programmed.
      wr(H_FLASH_CONTROL_REG, 16'h0008);
      load(16'h0000);
      wr(H_LAUNCH, 16'h0002);
      fire(2);
      wait_idle(1'b1);
      wr(H_FLASH_CONTROL_REG, 16'h0004);
      cmp_code(16'h0000, SRC_SEC, sb);
      stop_test();
   end
endmodule // tb_top
